// >>> hw/asc_pkg.sv
// Constants, register map and types for the serial slot output block.
// Assumes one 10 MHz ref_clk domain; everything else is sampled.
package asc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ASC_OFS_FRAMING = 8'h07;
    localparam logic [7:0] ASC_OFS_OUT_B = 8'h08;
    localparam logic [7:0] ASC_OFS_CHAIN_ERR = 8'h09;
    localparam logic [7:0] ASC_OFS_INDEX_A = 8'h0b;
    localparam logic [7:0] ASC_OFS_STATUS = 8'h10;
    localparam logic [7:0] ASC_OFS_MASK = 8'h11;
    localparam logic [7:0] ASC_OFS_STATE = 8'h12;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ASC_RST_FRAMING = 8'h30;
    localparam logic [7:0] ASC_RST_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ASC_FMT_LO = 6;
    localparam int ASC_WLEN_LO = 4;
    localparam int ASC_LSB_HALF_BIT = 7;
    localparam int ASC_KEEP_LO = 5;
    localparam int ASC_OFFSET_LO = 0;
    localparam int ASC_CHAIN_BIT = 7;
    localparam int ASC_FDD_BIT = 5;
    localparam int ASC_FRD_BIT = 4;
    localparam int ASC_LINE_BIT = 6;
    localparam int ASC_INDEX_LO = 0;
    localparam logic [7:0] ASC_FRAMING_MASK = 8'hf0;
    localparam logic [7:0] ASC_CHAIN_ERR_MASK = 8'hb0;
    localparam logic [7:0] ASC_CH1_MASK = 8'h7f;

    // Status / mask bits
    localparam int ASC_EV_FAULT = 0;
    localparam int ASC_EV_RESUME = 1;
    localparam int ASC_EV_WORD = 2;
    localparam int ASC_EV_N = 3;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ASC_FMT_TDM = 2'h0;
    localparam logic [1:0] ASC_FMT_I2S = 2'h1;
    localparam logic [1:0] ASC_FMT_LJ = 2'h2;
    localparam logic [1:0] ASC_KEEP_OFF = 2'h0;
    localparam logic [1:0] ASC_KEEP_ON = 2'h1;
    localparam logic [1:0] ASC_KEEP_ONE = 2'h2;
    localparam logic [1:0] ASC_KEEP_ONE_HALF = 2'h3;
    // Keeper hold in bit-clock half cycles
    localparam logic [1:0] ASC_KEEP_HALVES_ONE = 2'h2;
    localparam logic [1:0] ASC_KEEP_HALVES_ONE_HALF = 2'h3;
    localparam logic [5:0] ASC_RIGHT_BASE = 6'h20;
    localparam logic [11:0] ASC_I2S_DELAY = 12'h001;

    typedef enum logic [1:0] {
        ASC_RUN,
        ASC_FAULT,
        ASC_HOLD
    } asc_state_t;

    // Word and slot length in bits per code
    function automatic logic [5:0] asc_slot_bits(input logic [1:0] code);
        logic [5:0] r;
        r = 6'h20;
        unique case (code)
            2'h0: r = 6'h10;
            2'h1: r = 6'h14;
            2'h2: r = 6'h18;
            2'h3: r = 6'h20;
        endcase
        return r;
    endfunction : asc_slot_bits

endpackage : asc_pkg

// >>> hw/asc_pin_sync.sv
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes pins are asynchronous to ref_clk; edges come from stages two and three.
`timescale 1ns/10ps
module asc_pin_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Pins and results
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [1:0] fill;
    } asc_sync_t;

    // Edges held off until all three stages hold real pin samples
    localparam logic [1:0] FILL_FULL = 2'h3;

    asc_sync_t q;
    asc_sync_t d;

    if (WIDTH < 1) begin : g_bad_width
        $error("asc_pin_sync: WIDTH must be at least 1");
    end

    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.fill = (q.fill == FILL_FULL) ? q.fill : q.fill + 2'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.s2;
    assign rise = (q.fill == FILL_FULL) ? (q.s2 & ~q.s3) : '0;
    assign fall = (q.fill == FILL_FULL) ? (~q.s2 & q.s3) : '0;
endmodule : asc_pin_sync

// >>> hw/asc_slot_out.sv
// Serial audio output for channel 1 with slot placement, keeper and fault handling.
// Assumes bit clock and frame sync come from outside; data shift on bclk falling edges.
`timescale 1ns/10ps
module asc_slot_out
    import asc_pkg::*;
#(
    parameter int CNT_W = 12
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rd_data,
    // Audio word for channel 1
    input wire logic [31:0] sample_word,
    output logic sample_taken,
    // Link pins
    input wire logic bclk,
    input wire logic fsync,
    input wire logic chain_in,
    output logic primary_serial_out_o,
    output logic primary_serial_out_oe,
    output logic general_pin_one_o,
    output logic general_pin_one_oe,
    output logic keeper_en,
    // Interrupt
    output logic irq
);
    import asc_pkg::*;

    typedef struct packed {
        logic [7:0] framing;
        logic [7:0] out_b;
        logic [7:0] chain_err;
        logic [7:0] ch1;
        logic [ASC_EV_N-1:0] status;
        logic [ASC_EV_N-1:0] mask;
        asc_state_t state;
        logic fs_prev;
        logic chain_smp;
        logic right_half;
        logic [CNT_W-1:0] pos;
        logic [CNT_W-1:0] frame_cnt;
        logic [CNT_W-1:0] last_len;
        logic have_len;
        logic [31:0] word;
        logic lsb_active;
        logic [1:0] keep_cnt;
        logic prim_o;
        logic prim_oe;
        logic gp_o;
        logic gp_oe;
        logic keeper;
        logic irq;
        logic taken;
        logic [7:0] rd_data;
    } asc_regs_t;

    asc_regs_t q;
    asc_regs_t d;

    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (CNT_W < 12) begin : g_bad_cnt_w
        $error("asc_slot_out: CNT_W must be at least 12");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    asc_pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pins({chain_in, fsync, bclk}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] fmt;
        logic [5:0] slen;
        logic [4:0] offset;
        logic [5:0] index;
        logic [5:0] slot_in_half;
        logic two_ch;
        logic ref_edge;
        logic other_edge;
        logic [CNT_W-1:0] start;
        logic [CNT_W-1:0] idx;
        logic in_slot;
        logic bit_val;
        logic cfg_wr;
        logic clean;
        logic [ASC_EV_N-1:0] ev;
        logic [ASC_EV_N-1:0] clr;

        d = q;
        fmt = q.framing[ASC_FMT_LO +: 2];
        slen = asc_slot_bits(q.framing[ASC_WLEN_LO +: 2]);
        offset = q.out_b[ASC_OFFSET_LO +: 5];
        index = q.ch1[ASC_INDEX_LO +: 6];
        // Reserved framing code is served as TDM
        two_ch = (fmt == ASC_FMT_I2S) || (fmt == ASC_FMT_LJ);
        slot_in_half = two_ch ? (index & ~ASC_RIGHT_BASE) : index;
        ev = '0;
        clr = '0;
        ref_edge = 1'b0;
        other_edge = 1'b0;
        in_slot = 1'b0;
        bit_val = 1'b0;
        idx = '0;
        clean = 1'b0;

        // Slot start: offset plus slot index times slot length
        start = CNT_W'(offset)
            + (CNT_W'(slot_in_half) * CNT_W'(slen));
        if (fmt == ASC_FMT_I2S) begin
            start = start + CNT_W'(ASC_I2S_DELAY);
        end

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        cfg_wr = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                ASC_OFS_FRAMING: begin
                    d.framing = reg_wr_data & ASC_FRAMING_MASK;
                    cfg_wr = 1'b1;
                end
                ASC_OFS_OUT_B: begin
                    d.out_b = reg_wr_data;
                    cfg_wr = 1'b1;
                end
                ASC_OFS_CHAIN_ERR: begin
                    d.chain_err = reg_wr_data & ASC_CHAIN_ERR_MASK;
                    cfg_wr = 1'b1;
                end
                ASC_OFS_INDEX_A: begin
                    d.ch1 = reg_wr_data & ASC_CH1_MASK;
                    cfg_wr = 1'b1;
                end
                ASC_OFS_STATUS: clr = reg_wr_data[ASC_EV_N-1:0];
                ASC_OFS_MASK: d.mask = reg_wr_data[ASC_EV_N-1:0];
                default: ;
            endcase
        end

        // ----------------------------------------
        // Register reads, data valid one cycle later
        // ----------------------------------------
        d.rd_data = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ASC_OFS_FRAMING: d.rd_data = q.framing;
                ASC_OFS_OUT_B: d.rd_data = q.out_b;
                ASC_OFS_CHAIN_ERR: d.rd_data = q.chain_err;
                ASC_OFS_INDEX_A: d.rd_data = q.ch1;
                ASC_OFS_STATUS: d.rd_data = 8'(q.status);
                ASC_OFS_MASK: d.rd_data = 8'(q.mask);
                ASC_OFS_STATE: d.rd_data = 8'(q.state);
                default: d.rd_data = 8'h00;
            endcase
        end

        // Latch pulse lasts one cycle
        d.taken = 1'b0;

        // ----------------------------------------
        // Rising bit-clock edge: sample frame sync and chain input
        // ----------------------------------------
        if (pin_rise[0]) begin
            d.fs_prev = pin_lvl[1];
            d.chain_smp = pin_lvl[2];
            if (fmt == ASC_FMT_I2S) begin
                ref_edge = q.fs_prev && !pin_lvl[1];
                other_edge = !q.fs_prev && pin_lvl[1];
            end else begin
                ref_edge = !q.fs_prev && pin_lvl[1];
                other_edge = q.fs_prev && !pin_lvl[1];
            end
            // Half-cycle last bit: release line mid-bit
            if (q.lsb_active && q.out_b[ASC_LSB_HALF_BIT]) begin
                d.prim_oe = 1'b0;
                d.gp_oe = 1'b0;
            end
            if (q.keep_cnt != 2'h0) begin
                d.keep_cnt = q.keep_cnt - 2'h1;
            end
            if (ref_edge) begin
                clean = q.have_len && (q.frame_cnt == q.last_len);
                // Frame length changed: bus error
                if (q.have_len && !clean && q.state == ASC_RUN
                        && !q.chain_err[ASC_FDD_BIT]) begin
                    d.state = ASC_FAULT;
                    ev[ASC_EV_FAULT] = 1'b1;
                end
                if (q.state == ASC_FAULT && clean) begin
                    if (q.chain_err[ASC_FRD_BIT]) begin
                        d.state = ASC_HOLD;
                    end else begin
                        d.state = ASC_RUN;
                        ev[ASC_EV_RESUME] = 1'b1;
                    end
                end
                d.last_len = q.frame_cnt;
                d.have_len = 1'b1;
                d.frame_cnt = '0;
                d.pos = '0;
                d.right_half = 1'b0;
                d.word = sample_word;
                d.taken = 1'b1;
                ev[ASC_EV_WORD] = 1'b1;
            end else if (other_edge && two_ch) begin
                d.pos = '0;
                d.right_half = 1'b1;
            end
        end

        // ----------------------------------------
        // Falling bit-clock edge: launch the next bit
        // ----------------------------------------
        if (pin_fall[0]) begin
            idx = q.pos - start;
            in_slot = (q.state == ASC_RUN) && (q.pos >= start)
                && (idx < CNT_W'(slen))
                && (!two_ch || (q.right_half == index[5]));
            bit_val = q.word[5'(CNT_W'(slen) - 1'b1 - idx)];
            d.lsb_active = in_slot && (idx == CNT_W'(slen) - 1'b1);
            if (q.keep_cnt != 2'h0) begin
                d.keep_cnt = q.keep_cnt - 2'h1;
            end
            if (d.lsb_active) begin
                unique case (q.out_b[ASC_KEEP_LO +: 2])
                    ASC_KEEP_ONE: d.keep_cnt = ASC_KEEP_HALVES_ONE;
                    ASC_KEEP_ONE_HALF: d.keep_cnt = ASC_KEEP_HALVES_ONE_HALF;
                    ASC_KEEP_OFF, ASC_KEEP_ON: d.keep_cnt = 2'h0;
                endcase
            end
            d.prim_o = 1'b0;
            d.prim_oe = 1'b0;
            d.gp_o = 1'b0;
            d.gp_oe = 1'b0;
            if (in_slot && q.ch1[ASC_LINE_BIT]) begin
                d.gp_o = bit_val;
                d.gp_oe = 1'b1;
            end else if (in_slot) begin
                d.prim_o = bit_val;
                d.prim_oe = 1'b1;
            end
            // Daisy chain: pass upstream data on the primary line except during own slot on that line
            if (!(in_slot && !q.ch1[ASC_LINE_BIT])
                    && q.chain_err[ASC_CHAIN_BIT]) begin
                d.prim_o = q.chain_smp;
                d.prim_oe = 1'b1;
            end
            // Counters saturate instead of wrapping on overlong frames
            if (q.pos != '1) begin
                d.pos = q.pos + 1'b1;
            end
            if (q.frame_cnt != '1) begin
                d.frame_cnt = q.frame_cnt + 1'b1;
            end
        end

        // ----------------------------------------
        // Hold after error until host reprograms
        // ----------------------------------------
        if (q.state == ASC_HOLD && cfg_wr) begin
            d.state = ASC_RUN;
            d.have_len = 1'b0;
            ev[ASC_EV_RESUME] = 1'b1;
        end
        if (q.state != ASC_RUN && !in_slot && !q.chain_err[ASC_CHAIN_BIT]
                && pin_fall[0]) begin
            d.prim_oe = 1'b0;
        end

        // Keeper always on, or while the half-period count runs
        d.keeper = (q.out_b[ASC_KEEP_LO +: 2] == ASC_KEEP_ON)
            || (d.keep_cnt != 2'h0);

        // Sticky status, set wins over clear
        d.status = (q.status & ~clr) | ev;
        d.irq = |(d.status & d.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
            q.framing <= ASC_RST_FRAMING;
            q.out_b <= ASC_RST_ZERO;
            q.chain_err <= ASC_RST_ZERO;
            q.ch1 <= ASC_RST_ZERO;
            q.state <= ASC_RUN;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rd_data = q.rd_data;
    assign sample_taken = q.taken;
    assign primary_serial_out_o = q.prim_o;
    assign primary_serial_out_oe = q.prim_oe;
    assign general_pin_one_o = q.gp_o;
    assign general_pin_one_oe = q.gp_oe;
    assign keeper_en = q.keeper;
    assign irq = q.irq;
endmodule : asc_slot_out

// >>> bench/asc_slot_out_asserts.sv
// Checker for the serial slot output block.
// Assumes one ref_clk domain; shadows of two config registers and the chain bit kept here.
`timescale 1ns/10ps
module asc_slot_out_asserts
    import asc_pkg::*;
#(
    parameter int CNT_W = 12
) (
    // Clock, reset, register port
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rd_data,
    // Link side
    input wire logic sample_taken,
    input wire logic bclk,
    input wire logic primary_serial_out_o,
    input wire logic primary_serial_out_oe,
    input wire logic general_pin_one_oe,
    input wire logic keeper_en
);
    logic [7:0] outb_q;
    logic [7:0] ch1_q;
    logic chain_q;
    logic bclk_q;
    logic [3:0] fall_q;
    logic [3:0] rise_q;
    logic oe_fell;

    // Cycles since the last bit clock edge, saturating
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            outb_q <= 8'h00;
            ch1_q <= 8'h00;
            chain_q <= 1'b0;
            bclk_q <= 1'b1;
            fall_q <= 4'hf;
            rise_q <= 4'hf;
        end else begin
            if (reg_wr && reg_addr == ASC_OFS_OUT_B) begin
                outb_q <= reg_wr_data;
            end
            if (reg_wr && reg_addr == ASC_OFS_INDEX_A) begin
                ch1_q <= reg_wr_data;
            end
            if (reg_wr && reg_addr == ASC_OFS_CHAIN_ERR) begin
                chain_q <= reg_wr_data[ASC_CHAIN_BIT];
            end
            bclk_q <= bclk;
            fall_q <= (bclk_q && !bclk) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hf};
            rise_q <= (!bclk_q && bclk) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hf};
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_keep(logic [1:0] m);
        (outb_q[6:5] == m)[*3];
    endsequence
    sequence s_flat;
        (!chain_q)[*3];
    endsequence
    sequence s_oe_fell;
        $fell(primary_serial_out_oe) or $fell(general_pin_one_oe);
    endsequence

    chk_keeper_on: assert property (s_keep(ASC_KEEP_ON) |-> keeper_en)
        else $error("keeper not on in mode one");
    chk_keeper_off: assert property (s_keep(ASC_KEEP_OFF) |-> !keeper_en)
        else $error("keeper on in mode zero");
    chk_keeper_one: assert property (s_keep(ASC_KEEP_ONE) ##0 $rose(keeper_en)
        |-> keeper_en[*7] ##[1:2] !keeper_en) else $error("keeper pulse not one period");
    chk_keeper_half: assert property (s_keep(ASC_KEEP_ONE_HALF) ##0 $rose(keeper_en)
        |-> keeper_en[*8] ##1 keeper_en[*3] ##[1:3] !keeper_en)
        else $error("keeper pulse not one and a half periods");
    chk_data_moves: assert property (primary_serial_out_oe && $past(primary_serial_out_oe)
        && $changed(primary_serial_out_o) |-> fall_q inside {[4'h1:4'h6]})
        else $error("data changed away from a bit clock fall");
    chk_half_release: assert property (outb_q[7] ##0 s_oe_fell
        |-> rise_q inside {[4'h1:4'h6]}) else $error("half bit release not at rise");
    chk_full_release: assert property ((!outb_q[7] && !chain_q) ##0 s_oe_fell
        |-> fall_q inside {[4'h1:4'h6]}) else $error("full bit release not at fall");
    chk_lines_apart: assert property (s_flat
        |-> !(primary_serial_out_oe && general_pin_one_oe)) else $error("both lines driven");
    chk_read_slot: assert property (reg_rd && reg_addr == ASC_OFS_INDEX_A
        |=> reg_rd_data == (ch1_q & ASC_CH1_MASK)) else $error("slot register read wrong");
    chk_read_outb: assert property (reg_rd && reg_addr == ASC_OFS_OUT_B
        |=> reg_rd_data == outb_q) else $error("output config read wrong");
    chk_taken_pulse: assert property (sample_taken
        |-> rise_q inside {[4'h1:4'h6]} ##1 !sample_taken) else $error("sample latch misplaced");
endmodule : asc_slot_out_asserts

bind asc_slot_out asc_slot_out_asserts #(.CNT_W(CNT_W)) u_asserts (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .sample_taken(sample_taken), .bclk(bclk), .primary_serial_out_o(primary_serial_out_o),
    .primary_serial_out_oe(primary_serial_out_oe), .general_pin_one_oe(general_pin_one_oe),
    .keeper_en(keeper_en));

// >>> bench/asc_host_model.sv
// Receiving host: makes bit clock and frame sync, records both data lines.
// Assumes 800 ns bit clock, started off a ref_clk edge; clock stands high between frames.
`timescale 1ns/10ps
module asc_host_model (
    // Link clock, sync and upstream data
    output logic bclk,
    output logic fsync,
    output logic chain_in,
    // Data lines from the block
    input wire logic p_o,
    input wire logic p_oe,
    input wire logic g_o,
    input wire logic g_oe
);
    logic cap_p [64];
    logic cap_g [64];
    logic capl [64];

    initial begin
        bclk = 1'b1;
        fsync = 1'b0;
        chain_in = 1'b0;
    end

    // Released line recorded as z; drive sampled mid-high, release mid-low
    task automatic run_frame(input int n, input logic [63:0] fs);
        #50;
        for (int k = 0; k < n; k++) begin
            bclk = 1'b0;
            fsync = fs[k];
            chain_in = k[0];
            #200 capl[k] = p_oe | g_oe;
            #200 bclk = 1'b1;
            #200 cap_p[k] = p_oe ? p_o : 1'bz;
            cap_g[k] = g_oe ? g_o : 1'bz;
            #200;
        end
    endtask : run_frame
endmodule : asc_host_model

// >>> bench/asc_slot_out_tb.sv
// Testbench for the serial slot output block.
// Assumes the host model drives the link; expected bits come from the configured slot.
`timescale 1ns/10ps
module asc_slot_out_tb;
    import asc_pkg::*;
    localparam logic [31:0] WORD = 32'ha5c3_9e17;
    localparam logic [63:0] FS_TDM = 64'h1;
    localparam logic [7:0] OB [4] = '{8'h00, 8'hc5, 8'h7f, 8'ha3};
    localparam logic [7:0] CH [4] = '{8'h00, 8'h42, 8'h00, 8'h01};
    logic ref_clk, rst, reg_wr, reg_rd, sample_taken, bclk, fsync, chain_in;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic p_o, p_oe, g_o, g_oe, keeper_en, irq;
    int errors, n_checks;

    asc_slot_out DUT (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
        .sample_word(WORD), .sample_taken(sample_taken), .bclk(bclk), .fsync(fsync),
        .chain_in(chain_in), .primary_serial_out_o(p_o), .primary_serial_out_oe(p_oe),
        .general_pin_one_o(g_o), .general_pin_one_oe(g_oe), .keeper_en(keeper_en),
        .irq(irq));
    asc_host_model host (
        .bclk(bclk), .fsync(fsync), .chain_in(chain_in),
        .p_o(p_o), .p_oe(p_oe), .g_o(g_o), .g_oe(g_oe));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk_byte("reg_rd_data", e, reg_rd_data);
    endtask : rd_chk
    task automatic irq_chk(input logic e);
        repeat (2) @(negedge ref_clk);
        chk_bit("irq", e, irq);
    endtask : irq_chk
    task automatic frames(input int n, input logic [63:0] fs);
        repeat (n) host.run_frame(64, fs);
    endtask : frames
    // Slot placed s bits after reference period r; c is the forwarded chain bit
    task automatic chk_frame(input int r, input int s, input int wl, input bit sec,
                             input bit chn, input bit lsb);
        int q;
        logic in, v, c;
        for (int k = r + 1; k < 64; k++) begin
            q = k - 1 - r;
            in = q >= s && q < s + wl;
            v = in ? WORD[wl - 1 - q + s] : 1'bz;
            c = chn ? ~k[0] : 1'bz;
            chk_bit("primary", (sec || !in) ? c : v, host.cap_p[k]);
            chk_bit("general", sec ? v : 1'bz, host.cap_g[k]);
        end
        if (r + s + wl + 1 < 64) begin
            chk_bit("last_bit_drive", !lsb, host.capl[r + s + wl + 1]);
        end
    endtask : chk_frame

    task automatic t_regs;
        rd_chk(ASC_OFS_FRAMING, ASC_RST_FRAMING);
        rd_chk(ASC_OFS_OUT_B, ASC_RST_ZERO);
        rd_chk(ASC_OFS_CHAIN_ERR, ASC_RST_ZERO);
        rd_chk(ASC_OFS_INDEX_A, ASC_RST_ZERO);
        wr(ASC_OFS_OUT_B, 8'hff);
        wr(ASC_OFS_CHAIN_ERR, 8'hff);
        wr(ASC_OFS_INDEX_A, 8'hff);
        rd_chk(ASC_OFS_OUT_B, 8'hff);
        rd_chk(ASC_OFS_CHAIN_ERR, ASC_CHAIN_ERR_MASK);
        rd_chk(ASC_OFS_INDEX_A, ASC_CH1_MASK);
        rd_chk(8'h0a, 8'h00);
        wr(ASC_OFS_INDEX_A, 8'h00);
        wr(ASC_OFS_CHAIN_ERR, 8'h00);
        wr(ASC_OFS_OUT_B, 8'h00);
        wr(ASC_OFS_FRAMING, 8'h00);
    endtask : t_regs
    task automatic t_tdm;
        for (int i = 0; i < 4; i++) begin
            wr(ASC_OFS_OUT_B, OB[i]);
            wr(ASC_OFS_INDEX_A, CH[i]);
            frames(2, FS_TDM);
            chk_frame(0, OB[i][4:0] + CH[i][5:0] * 16, 16, CH[i][6], 0, OB[i][7]);
        end
        wr(ASC_OFS_OUT_B, 8'h00);
        wr(ASC_OFS_FRAMING, 8'h20);
        wr(ASC_OFS_CHAIN_ERR, 8'h80);
        wr(ASC_OFS_INDEX_A, 8'h01);
        frames(2, FS_TDM);
        chk_frame(0, 24, 24, 0, 1, 0);
        wr(ASC_OFS_CHAIN_ERR, 8'h00);
        wr(ASC_OFS_FRAMING, 8'h00);
        wr(ASC_OFS_INDEX_A, 8'h00);
    endtask : t_tdm
    task automatic t_fault;
        wr(ASC_OFS_STATUS, 8'h07);
        wr(ASC_OFS_MASK, 8'h01);
        host.run_frame(48, FS_TDM);
        frames(2, FS_TDM);
        chk_frame(0, 64, 16, 0, 0, 0);
        rd_chk(ASC_OFS_STATE, 8'h01);
        irq_chk(1'b1);
        wr(ASC_OFS_MASK, 8'h02);
        irq_chk(1'b0);
        frames(1, FS_TDM);
        rd_chk(ASC_OFS_STATE, 8'h00);
        irq_chk(1'b1);
        wr(ASC_OFS_STATUS, 8'h07);
        irq_chk(1'b0);
        wr(ASC_OFS_CHAIN_ERR, 8'h10);
        host.run_frame(48, FS_TDM);
        frames(4, FS_TDM);
        rd_chk(ASC_OFS_STATE, 8'h02);
        wr(ASC_OFS_INDEX_A, 8'h00);
        rd_chk(ASC_OFS_STATE, 8'h00);
        wr(ASC_OFS_CHAIN_ERR, 8'h20);
        host.run_frame(48, FS_TDM);
        frames(2, FS_TDM);
        rd_chk(ASC_OFS_STATE, 8'h00);
    endtask : t_fault
    task automatic t_2ch;
        wr(ASC_OFS_FRAMING, 8'h80);
        wr(ASC_OFS_OUT_B, 8'h02);
        wr(ASC_OFS_INDEX_A, 8'h20);
        frames(2, 64'h0000_0000_ffff_ffff);
        chk_frame(32, 2, 16, 0, 0, 0);
        wr(ASC_OFS_FRAMING, 8'h40);
        wr(ASC_OFS_OUT_B, 8'h00);
        wr(ASC_OFS_INDEX_A, 8'h01);
        frames(2, 64'hffff_fffe_0000_0000);
        chk_frame(0, 17, 16, 0, 0, 0);
    endtask : t_2ch

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #3000000;
        errors++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        errors = 0;
        n_checks = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        frames(1, FS_TDM);
        t_tdm();
        t_fault();
        t_2ch();
        report_and_stop();
    end
endmodule : asc_slot_out_tb
